//--- core/odc_regs.svh
// register map, field positions and reset values of the oscillator divider control block
`ifndef ODC_REGS_SVH
`define ODC_REGS_SVH
`define ODC_ADDR_CTRL     4'h0
`define ODC_ADDR_KEY      4'h4
`define ODC_KEY1          32'hAA996655
`define ODC_KEY2          32'h556699AA
`define ODC_PLL_DIV_LSB   27
`define ODC_FRC_DIV_LSB   24
`define ODC_SOSC_BIT      22
`define ODC_PB_RDY_BIT    21
`define ODC_PB_DIV_LSB    19
`define ODC_PLL_MULT_LSB  16
`define ODC_NEW_SRC_LSB   8
`define ODC_LANE_PLL_FRC  3
`define ODC_LANE_PB_MULT  2
`define ODC_LANE_NEW_SRC  1
`define ODC_FRC_DIV_RST   3'h1
`define ODC_DIV_CODE_MAX  3'h7
`define ODC_DIV_LIM_MAX   8'hFF
`define ODC_RESP_OKAY     2'h0
`define ODC_RESP_SLVERR   2'h2
`endif

//--- core/odc_pkg.sv
// types shared by the oscillator divider control block
package odc_pkg;
  typedef struct packed {
    logic [2:0] pll_post_div_sel;
    logic [2:0] pll_multiplier_sel;
    logic [1:0] periph_bus_div_sel;
    logic [2:0] new_source_sel;
  } odc_cfg_t;

  typedef struct packed {
    logic clk;
    logic tick;
  } odc_div_out_t;

  typedef enum logic [1:0] {
    ODC_LOCKED,
    ODC_KEY1_SEEN,
    ODC_UNLOCKED
  } odc_lock_t;
endpackage

//--- core/odc_div.sv
// glitch-free power-of-two divider counting source edges
`timescale 1ns/1ps
`include "odc_regs.svh"
module odc_div
  import odc_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         src_edge,
  input  wire logic [2:0]   sel,
  input  wire logic [2:0]   sel_rst,
  output odc_div_out_t      div_out,
  output logic              busy
);
  logic [7:0]   cnt_q;
  logic [2:0]   app_q;
  odc_div_out_t out_q;
  logic [7:0]   lim;
  logic         wrap;

  // edges per output half period minus one; code 7 is 256, not 128
  assign lim  = (app_q == `ODC_DIV_CODE_MAX) ? `ODC_DIV_LIM_MAX : 8'((9'h1 << app_q) - 9'h1);
  assign wrap = src_edge && (cnt_q == lim);
  assign busy = (sel != app_q);
  assign div_out = out_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      app_q <= sel_rst;
      out_q <= '0;
    end else begin
      out_q.tick <= wrap;
      if (wrap) begin
        cnt_q     <= 8'h00;
        out_q.clk <= ~out_q.clk;
        app_q     <= sel; // R9
      end else if (src_edge) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  property p_wrap_toggle;
    @(posedge aclk) disable iff (!aresetn)
    wrap |=> (out_q.clk != $past(out_q.clk)) && out_q.tick && (cnt_q == 8'h00);
  endproperty
  a_wrap_toggle: assert property (p_wrap_toggle) else $error("divider did not toggle at terminal count"); // R1

  property p_apply_boundary;
    @(posedge aclk) disable iff (!aresetn)
    (app_q != $past(app_q)) |-> $past(wrap);
  endproperty
  a_apply_boundary: assert property (p_apply_boundary) else $error("divider changed between output edges"); // R9
endmodule

//--- core/odc_top.sv
// oscillator divider control register block with AXI4-Lite slave
// Function
// [R1] pll post divider codes give 1..64, 256
// [R2] fast rc divider same codes, default two
// [R3] read-only secondary oscillator stable flag bit 22
// [R4] periph divisor writable only while flag set
// [R5] periph bus clock divides system clock 1..8
// [R6] control writes need a completed unlock first
// [R7] bits 31-30 and 23 read zero
// [R8] marked fields load configuration bits at reset
// [R9] divider changes only at output clock boundary
`timescale 1ns/1ps
`include "odc_regs.svh"
module odc_top
  import odc_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [3:0]   awaddr,
  input  wire logic         wvalid,
  output logic              wready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  output logic              bvalid,
  input  wire logic         bready,
  output logic [1:0]        bresp,
  input  wire logic         arvalid,
  output logic              arready,
  input  wire logic [3:0]   araddr,
  output logic              rvalid,
  input  wire logic         rready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  input  wire logic         pll_out_clk,
  input  wire logic         fast_rc_oscillator,
  input  wire logic         secondary_osc_stable,
  input  odc_cfg_t          cfg,
  output logic              pll_div_clk,
  output logic              fast_rc_div_clk,
  output logic              periph_bus_clock,
  output logic [2:0]        pll_multiplier_sel,
  output logic [2:0]        new_source_sel
);
  logic         aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [3:0]   aw_addr_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic [1:0]   bresp_q, rresp_q;
  logic [31:0]  rdata_q;
  logic         rd_ctrl_q;
  odc_lock_t    lock_q;
  logic [2:0]   pll_post_div_sel_q, fast_rc_div_sel_q, pll_mult_q, new_src_q;
  logic [1:0]   periph_bus_div_sel_q;
  logic         pb_wr_q, pll_prev_q, frc_prev_q;
  logic         aw_take, w_take, ar_take, do_write, wr_ctrl, wr_key, ar_ctrl;
  logic         aw_have_d, w_have_d, bvalid_d, rvalid_d;
  logic         pb_busy;
  logic [31:0]  rd_word;
  odc_div_out_t pll_o, frc_o, pb_o;

  assign aw_take   = awvalid && awready_q;
  assign w_take    = wvalid && wready_q;
  assign ar_take   = arvalid && arready_q;
  assign do_write  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl   = (aw_addr_q == `ODC_ADDR_CTRL);
  assign wr_key    = (aw_addr_q == `ODC_ADDR_KEY);
  assign ar_ctrl   = (araddr == `ODC_ADDR_CTRL);
  assign aw_have_d = (aw_have_q || aw_take) && !do_write;
  assign w_have_d  = (w_have_q || w_take) && !do_write;
  assign bvalid_d  = (bvalid_q && !bready) || do_write;
  assign rvalid_d  = (rvalid_q && !rready) || ar_take;

  // write channels: address and data held independently, answered one cycle after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ODC_RESP_OKAY;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q  <= !w_have_d && !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        // a locked control write is dropped silently, not an error
        bresp_q <= (wr_ctrl || wr_key) ? `ODC_RESP_OKAY : `ODC_RESP_SLVERR;
      end
    end
  end

  // unlock sequence: two keys back to back arm exactly one control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= ODC_LOCKED;
    end else if (do_write) begin
      if (wr_key && w_data_q == `ODC_KEY1) begin
        lock_q <= ODC_KEY1_SEEN;
      end else if (wr_key && lock_q == ODC_KEY1_SEEN && w_data_q == `ODC_KEY2) begin
        lock_q <= ODC_UNLOCKED; // R6
      end else begin
        lock_q <= ODC_LOCKED; // R6
      end
    end
  end

  // control fields; sync reset doubles as power-on load of configuration bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_post_div_sel_q   <= cfg.pll_post_div_sel; // R8
      pll_mult_q           <= cfg.pll_multiplier_sel; // R8
      periph_bus_div_sel_q <= cfg.periph_bus_div_sel; // R8
      new_src_q            <= cfg.new_source_sel; // R8
      fast_rc_div_sel_q    <= `ODC_FRC_DIV_RST; // R2
    end else if (do_write && wr_ctrl && lock_q == ODC_UNLOCKED) begin // R6
      if (w_strb_q[`ODC_LANE_PLL_FRC]) begin
        pll_post_div_sel_q <= w_data_q[`ODC_PLL_DIV_LSB +: 3]; // R1
        fast_rc_div_sel_q  <= w_data_q[`ODC_FRC_DIV_LSB +: 3]; // R2
      end
      if (w_strb_q[`ODC_LANE_PB_MULT]) begin
        pll_mult_q <= w_data_q[`ODC_PLL_MULT_LSB +: 3];
        if (pb_wr_q) begin
          periph_bus_div_sel_q <= w_data_q[`ODC_PB_DIV_LSB +: 2]; // R4
        end
      end
      if (w_strb_q[`ODC_LANE_NEW_SRC]) begin
        new_src_q <= w_data_q[`ODC_NEW_SRC_LSB +: 3];
      end
    end
  end

  // read word; unimplemented and excluded positions stay zero
  always_comb begin
    rd_word = 32'h0000_0000; // R7
    rd_word[`ODC_PLL_DIV_LSB +: 3]  = pll_post_div_sel_q;
    rd_word[`ODC_FRC_DIV_LSB +: 3]  = fast_rc_div_sel_q;
    rd_word[`ODC_SOSC_BIT]          = secondary_osc_stable; // R3
    rd_word[`ODC_PB_RDY_BIT]        = pb_wr_q; // R4
    rd_word[`ODC_PB_DIV_LSB +: 2]   = periph_bus_div_sel_q;
    rd_word[`ODC_PLL_MULT_LSB +: 3] = pll_mult_q;
    rd_word[`ODC_NEW_SRC_LSB +: 3]  = new_src_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `ODC_RESP_OKAY;
      rd_ctrl_q <= 1'b0;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rd_ctrl_q <= ar_ctrl;
        rdata_q   <= ar_ctrl ? rd_word : 32'h0000_0000;
        rresp_q   <= (ar_ctrl || araddr == `ODC_ADDR_KEY) ? `ODC_RESP_OKAY : `ODC_RESP_SLVERR;
      end
    end
  end

  // writable flag is a flop so a bus write never races a pending divisor change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_wr_q    <= 1'b1;
      // track the pins through reset so release shows no false source edge
      pll_prev_q <= pll_out_clk;
      frc_prev_q <= fast_rc_oscillator;
    end else begin
      pb_wr_q    <= !pb_busy; // R4
      pll_prev_q <= pll_out_clk;
      frc_prev_q <= fast_rc_oscillator;
    end
  end

  odc_div u_pll_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .src_edge (pll_out_clk ^ pll_prev_q),
    .sel      (pll_post_div_sel_q),
    .sel_rst  (cfg.pll_post_div_sel),
    .div_out  (pll_o),
    .busy     ()
  ); // R1

  odc_div u_frc_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .src_edge (fast_rc_oscillator ^ frc_prev_q),
    .sel      (fast_rc_div_sel_q),
    .sel_rst  (`ODC_FRC_DIV_RST),
    .div_out  (frc_o),
    .busy     ()
  ); // R2

  // every system clock is one source event, so the tick marks each peripheral cycle
  odc_div u_pb_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .src_edge (1'b1),
    .sel      ({1'b0, periph_bus_div_sel_q}),
    .sel_rst  ({1'b0, cfg.periph_bus_div_sel}),
    .div_out  (pb_o),
    .busy     (pb_busy)
  ); // R5

  assign awready            = awready_q;
  assign wready             = wready_q;
  assign bvalid             = bvalid_q;
  assign bresp              = bresp_q;
  assign arready            = arready_q;
  assign rvalid             = rvalid_q;
  assign rdata              = rdata_q;
  assign rresp              = rresp_q;
  assign pll_div_clk        = pll_o.clk;
  assign fast_rc_div_clk    = frc_o.clk;
  assign periph_bus_clock   = pb_o.tick;
  assign pll_multiplier_sel = pll_mult_q;
  assign new_source_sel     = new_src_q;

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
    (rvalid_q && rd_ctrl_q) |-> (rdata_q[31:30] == 2'b00) && !rdata_q[23];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // R7

  property p_sosc_follow;
    @(posedge aclk) disable iff (!aresetn)
    (ar_take && ar_ctrl) |=> rvalid_q && (rdata_q[`ODC_SOSC_BIT] == $past(secondary_osc_stable));
  endproperty
  a_sosc_follow: assert property (p_sosc_follow) else $error("stable flag read wrong"); // R3

  property p_locked_ignore;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_ctrl && lock_q != ODC_UNLOCKED) |=>
      $stable(pll_post_div_sel_q) && $stable(fast_rc_div_sel_q) && $stable(periph_bus_div_sel_q);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("locked write changed a field"); // R6

  property p_unlock_once;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_ctrl) |=> (lock_q == ODC_LOCKED);
  endproperty
  a_unlock_once: assert property (p_unlock_once) else $error("unlock not consumed by write"); // R6

  property p_pb_refuse;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_ctrl && !pb_wr_q) |=> $stable(periph_bus_div_sel_q);
  endproperty
  a_pb_refuse: assert property (p_pb_refuse) else $error("divisor written while not writable"); // R4

  property p_cfg_load;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (pll_post_div_sel_q == $past(cfg.pll_post_div_sel))
      && (periph_bus_div_sel_q == $past(cfg.periph_bus_div_sel));
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("configuration bits not loaded at reset"); // R8

  property p_frc_default;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (fast_rc_div_sel_q == `ODC_FRC_DIV_RST);
  endproperty
  a_frc_default: assert property (p_frc_default) else $error("fast rc divider default wrong"); // R2
endmodule

//--- tb/odc_top_test.sv
// self-checking bench for the oscillator divider control block
`timescale 1ns/1ps
`include "odc_regs.svh"
module odc_top_test import odc_pkg::*;;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, seed, m;
  logic [1:0]  bresp, rresp;
  logic        pll_out_clk, fast_rc_oscillator, secondary_osc_stable;
  odc_cfg_t    cfg;
  logic        pll_div_clk, fast_rc_div_clk, periph_bus_clock;
  logic [2:0]  pll_multiplier_sel, new_source_sel;
  int          n_mismatch, compares;

  odc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pll_out_clk(pll_out_clk), .fast_rc_oscillator(fast_rc_oscillator),
    .secondary_osc_stable(secondary_osc_stable), .cfg(cfg), .pll_div_clk(pll_div_clk),
    .fast_rc_div_clk(fast_rc_div_clk), .periph_bus_clock(periph_bus_clock),
    .pll_multiplier_sel(pll_multiplier_sel), .new_source_sel(new_source_sel));

  always #5 aclk = ~aclk;

  // both sources flip every cycle, so one cycle counts one source edge
  always @(posedge aclk) begin
    pll_out_clk <= ~pll_out_clk;
    fast_rc_oscillator <= ~fast_rc_oscillator;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int fac(input logic [2:0] c);
    return (c == 3'h7) ? 256 : (1 << c);
  endfunction

  // lane 3 holds both dividers, lane 2 periph and multiplier, lane 1 new source
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] k;
    k = {2'h0, {6{s[3]}}, 3'h0, {5{s[2]}}, 5'h0, {3{s[1]}}, 8'h0};
    return (o & ~k) | (d & k);
  endfunction

  // stable flag is live; writable flag is high once any divisor change has settled
  function automatic logic [31:0] expv(input logic [31:0] mm);
    return mm | {9'h0, secondary_osc_stable, 1'b1, 21'h0};
  endfunction

  function automatic logic sig(input int w);
    return (w == 0) ? pll_div_clk : (w == 1) ? fast_rc_div_clk : periph_bus_clock;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    tally_and_finish();
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic pa, pw;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    while ((pa | pw) && n < 50) begin
      @(posedge aclk);
      n++;
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) hang();
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) hang();
  endtask

  task automatic unlock();
    logic [1:0] r;
    axw(`ODC_ADDR_KEY, `ODC_KEY1, 4'hF, r);
    axw(`ODC_ADDR_KEY, `ODC_KEY2, 4'hF, r);
  endtask

  task automatic rdchk(input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axr(`ODC_ADDR_CTRL, d, r);
    chk(what, d, expv(m));
    chk("field outputs", {26'h0, pll_multiplier_sel, new_source_sel}, {26'h0, m[18:16], m[10:8]});
  endtask

  // second event spacing; the first gap may straddle a divider change
  task automatic gap(input int w, output int n);
    logic p, c, ev;
    int   e;
    p = sig(w);
    for (e = 0; e < 2; e++) begin
      n = 0;
      ev = 1'b0;
      while (!ev && n < 600) begin
        @(posedge aclk);
        c = sig(w);
        n++;
        ev = (w == 2) ? (c === 1'b1) : (c !== p);
        p = c;
      end
      if (!ev) hang();
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n, i;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {pll_out_clk, fast_rc_oscillator, secondary_osc_stable} = '0;
    n_mismatch = 0;
    compares = 0;
    seed = 32'h5C;
    d = rnd();
    cfg = d[10:0];
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    m = {2'h0, cfg.pll_post_div_sel, 3'h1, 3'h0, cfg.periph_bus_div_sel, cfg.pll_multiplier_sel, 5'h0,
         cfg.new_source_sel, 8'h0};
    rdchk("reset image");
    for (i = 0; i < 2; i++) begin
      secondary_osc_stable <= ~secondary_osc_stable;
      repeat (3) @(posedge aclk);
      rdchk("stable flag");
    end
    axw(`ODC_ADDR_CTRL, rnd(), 4'hF, r);
    chk("locked bresp", {30'h0, r}, {30'h0, `ODC_RESP_OKAY});
    axw(`ODC_ADDR_KEY, `ODC_KEY1, 4'hF, r);
    axw(`ODC_ADDR_KEY, rnd(), 4'hF, r);
    axw(`ODC_ADDR_KEY, `ODC_KEY2, 4'hF, r);
    axw(`ODC_ADDR_CTRL, rnd(), 4'hF, r);
    repeat (20) @(posedge aclk);
    rdchk("locked image");
    axw(4'h8, rnd(), 4'hF, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, `ODC_RESP_SLVERR});
    axr(4'h8, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, `ODC_RESP_SLVERR});
    chk("unmapped rdata", d, 32'h0);
    axr(`ODC_ADDR_KEY, d, r);
    chk("key rdata", d, 32'h0);
    // every divider code; the write after the change must be dropped as relocked
    for (i = 0; i < 8; i++) begin
      d = rnd();
      d[29:24] = {i[2:0], ~i[2:0]};
      d[20:19] = i[1:0];
      unlock();
      axw(`ODC_ADDR_CTRL, d, 4'hF, r);
      m = merge(m, d, 4'hF);
      axw(`ODC_ADDR_CTRL, ~d, 4'hF, r);
      repeat (600) @(posedge aclk);
      rdchk("divider image");
      gap(0, n);
      chk("pll gap", n, fac(i[2:0]));
      gap(1, n);
      chk("fast rc gap", n, fac(~i[2:0]));
      gap(2, n);
      chk("periph gap", n, 32'h1 << i[1:0]);
    end
    for (i = 0; i < 6; i++) begin
      d = rnd();
      n = rnd();
      unlock();
      axw(`ODC_ADDR_CTRL, d, n[3:0], r);
      m = merge(m, d, n[3:0]);
      repeat (30) @(posedge aclk);
      rdchk("lane image");
    end
    tally_and_finish();
  end
endmodule
